// File: logic/plrs_pkg.sv
// Constants, enumerations and carrier structs for the power loss restart sequencer.
// Assumes a single 250 MHz controller clock with a synchronous active-high reset.
package plrs_pkg;

    // Clock period and the millisecond tick derived from it.
    localparam int CLK_PERIOD_NS = 4;
    localparam int MS_NS = 1000000;
    localparam int CYCLES_PER_MS_DEF = MS_NS / CLK_PERIOD_NS;
    localparam int TICK_W = 20;

    // Wait window for a run command after the ready-to-run state.
    localparam int RUN_WAIT_S = 2;
    localparam logic [15:0] RUN_WAIT_MS = 16'(RUN_WAIT_S * 1000);

    // Mode selection codes for the power loss restart mode.
    localparam logic [2:0] MODE_TRIP_NOW = 3'h0;
    localparam logic [2:0] MODE_TRIP_RECOVER = 3'h1;
    localparam logic [2:0] MODE_DECEL_TRIP = 3'h2;
    localparam logic [2:0] MODE_RESTART_SAVED = 3'h4;
    localparam logic [2:0] MODE_RESTART_START = 3'h5;

    // Run command source codes; 2 and 3 fix the rotation direction.
    localparam logic [1:0] SRC_KEYPAD_TERM = 2'h0;
    localparam logic [1:0] SRC_FIXED_FWD = 2'h2;
    localparam logic [1:0] SRC_FIXED_REV = 2'h3;

    // Frequency fall rate in units of 0.01 Hz/s; 0.00 and 999 are special codes.
    localparam logic [16:0] FALL_FOLLOW_DECEL = 17'h00000;
    localparam logic [16:0] FALL_PI_CODE = 17'h1863C;

    // Reset values.
    localparam logic [15:0] FREQ_RST = 16'h0000;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [TICK_W-1:0] TICK_RST = 20'h00000;

    typedef enum logic [1:0] {FALL_DECEL_TIME, FALL_SET_RATE, FALL_FIXED_PI} plrs_fall_type;

    typedef enum logic [3:0] {
        ST_STOP, ST_RUN, ST_DECEL, ST_LOST, ST_CHARGE, ST_WAIT_RUN, ST_LIMIT, ST_ACCEL, ST_TRIP
    } plrs_state_type;

    // Configuration settings of the sequencer; restart_delay_time is in milliseconds.
    typedef struct packed {
        logic [2:0] power_loss_restart_mode;
        logic [1:0] run_command_source;
        logic [16:0] frequency_fall_rate;
        logic [15:0] starting_frequency_setting;
        logic [15:0] restart_delay_time;
    } plrs_cfg_type;

    // Supply observations from the DC link monitor.
    typedef struct packed {
        logic below_uv;
        logic below_cont;
        logic charge_done;
    } plrs_mains_type;

endpackage

// File: logic/plrs_ms_timer.sv
// Millisecond down-counter with a sticky done flag.
// Assumes a one-cycle tick every millisecond from the parent.
module plrs_ms_timer
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic start,
    input wire logic [15:0] load_ms,
    input wire logic tick,
    output logic done_q
);
    import plrs_pkg::*;

    logic [15:0] count_q;
    logic busy_q;

    // A new start always wins, so a fresh failure restarts the measurement.
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            count_q <= COUNT_RST;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end
        else if (start)
        begin
            count_q <= load_ms;
            busy_q <= 1'b1;
            done_q <= 1'b0;
        end
        // The first tick after a start may come at once, so one tick more than the
        // load is counted; the full span then always passes before done rises.
        else if (busy_q && tick && count_q == COUNT_RST)
        begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
        end
        else if (busy_q && tick)
        begin
            count_q <= count_q - 16'h0001;
        end
    end

endmodule

// File: logic/plrs_sequencer.sv
// Power loss restart sequencer: trip, decelerate or restart after a mains dip.
// Assumes synchronous inputs from the DC link monitor, the run sources and the power stage.
module plrs_sequencer
#(
    parameter int unsigned CYCLES_PER_MS = plrs_pkg::CYCLES_PER_MS_DEF
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input plrs_pkg::plrs_cfg_type cfg,
    input plrs_pkg::plrs_mains_type mains,
    input wire logic keypad_run_command,
    input wire logic forward_run_command,
    input wire logic reverse_run_command,
    input wire logic coast_stop_command,
    input wire logic alarm_reset,
    input wire logic decel_done,
    input wire logic speed_matched,
    input wire logic [15:0] output_freq,
    output logic output_enable_q,
    output logic uv_alarm_q,
    output logic decel_stop_q,
    output logic restart_pending_q,
    output logic restart_start_q,
    output logic limit_active_q,
    output logic accel_back_q,
    output plrs_pkg::plrs_fall_type fall_mode_q,
    output logic [15:0] freq_cmd_q,
    output logic [15:0] saved_freq_q
);
    import plrs_pkg::*;

    plrs_state_type state_q, state_d;
    logic [TICK_W-1:0] tick_cnt_q;
    logic tick_q;
    logic run_seen_q;
    logic dly_done, wait_done;
    logic ev_fail, ev_restart, ev_cancel, ev_alarm, ev_start;
    logic run_present, fixed_src, restart_mode, enter_wait;

    assign run_present = keypad_run_command | forward_run_command | reverse_run_command;
    assign fixed_src = cfg.run_command_source == SRC_FIXED_FWD ||
                       cfg.run_command_source == SRC_FIXED_REV;
    assign restart_mode = cfg.power_loss_restart_mode == MODE_RESTART_SAVED ||
                          cfg.power_loss_restart_mode == MODE_RESTART_START;
    assign enter_wait = state_d == ST_WAIT_RUN && state_q != ST_WAIT_RUN;

    // Millisecond tick; the period is a parameter so simulation can shorten it.
    always_ff @(posedge sys_clk)
    begin
        if (reset || tick_cnt_q == TICK_W'(CYCLES_PER_MS - 1))
            tick_cnt_q <= TICK_RST;
        else
            tick_cnt_q <= tick_cnt_q + 20'h00001;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            tick_q <= 1'b0;
        else
            tick_q <= tick_cnt_q == TICK_W'(CYCLES_PER_MS - 1);
    end

    // Restart delay runs from the failure itself, not from power return.
    plrs_ms_timer delay_timer
    (
        .sys_clk(sys_clk),
        .reset(reset),
        .start(ev_fail),
        .load_ms(cfg.restart_delay_time),
        .tick(tick_q),
        .done_q(dly_done)
    );

    // The run command window opens on entry to ready-to-run.
    plrs_ms_timer wait_timer
    (
        .sys_clk(sys_clk),
        .reset(reset),
        .start(enter_wait),
        .load_ms(RUN_WAIT_MS),
        .tick(tick_q),
        .done_q(wait_done)
    );

    // Sequencer decisions. Illegal mode codes fall back to the safest action, an immediate trip.
    always_comb
    begin
        state_d = state_q;
        ev_fail = 1'b0;
        ev_restart = 1'b0;
        ev_cancel = 1'b0;
        ev_alarm = 1'b0;
        ev_start = 1'b0;
        unique case (state_q)
            ST_STOP:
                if (run_present && !coast_stop_command && !mains.below_uv && mains.charge_done)
                begin
                    ev_start = 1'b1;
                    state_d = ST_RUN;
                end
            ST_RUN:
                if (coast_stop_command || !run_present)
                    state_d = ST_STOP;
                else if (cfg.power_loss_restart_mode == MODE_DECEL_TRIP && mains.below_cont)
                    state_d = ST_DECEL;
                else if (mains.below_uv)
                begin
                    ev_fail = 1'b1;
                    if (cfg.power_loss_restart_mode == MODE_TRIP_RECOVER || restart_mode)
                        state_d = ST_LOST;
                    else
                    begin
                        ev_alarm = 1'b1;
                        state_d = ST_TRIP;
                    end
                end
            ST_DECEL:
                if (decel_done)
                begin
                    ev_alarm = 1'b1;
                    state_d = ST_TRIP;
                end
            ST_LOST:
                if (restart_pending_q && coast_stop_command)
                begin
                    ev_cancel = 1'b1;
                    state_d = ST_STOP;
                end
                else if (!mains.below_uv && !restart_pending_q)
                begin
                    ev_alarm = 1'b1;
                    state_d = ST_TRIP;
                end
                else if (!mains.below_uv)
                    state_d = ST_CHARGE;
            ST_CHARGE:
                if (coast_stop_command)
                begin
                    ev_cancel = 1'b1;
                    state_d = ST_STOP;
                end
                else if (mains.below_uv)
                    state_d = ST_LOST;
                else if (mains.charge_done)
                    state_d = ST_WAIT_RUN;
            ST_WAIT_RUN:
                if (coast_stop_command)
                begin
                    ev_cancel = 1'b1;
                    state_d = ST_STOP;
                end
                else if (mains.below_uv)
                    state_d = ST_LOST;
                else if ((run_seen_q || (run_present && !wait_done)) && dly_done)
                begin
                    ev_restart = 1'b1;
                    if (cfg.power_loss_restart_mode == MODE_RESTART_SAVED)
                        state_d = ST_LIMIT;
                    else
                        state_d = ST_RUN;
                end
                else if (wait_done && !run_seen_q)
                begin
                    ev_cancel = 1'b1;
                    state_d = ST_STOP;
                end
            ST_LIMIT:
                if (coast_stop_command)
                    state_d = ST_STOP;
                else if (speed_matched)
                    state_d = ST_ACCEL;
            ST_ACCEL:
                if (coast_stop_command)
                    state_d = ST_STOP;
                else if (output_freq >= saved_freq_q)
                    state_d = ST_RUN;
            ST_TRIP:
                if (alarm_reset)
                    state_d = ST_STOP;
            default:
                state_d = ST_STOP;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            state_q <= ST_STOP;
        else
            state_q <= state_d;
    end

    // A run command seen inside the window is kept until the delay allows the restart.
    always_ff @(posedge sys_clk)
    begin
        if (reset || state_d != ST_WAIT_RUN)
            run_seen_q <= 1'b0;
        else if (enter_wait && fixed_src)
            run_seen_q <= 1'b1;
        else if (run_present && !wait_done)
            run_seen_q <= 1'b1;
    end

    // Pending flag; a new failure wins over a same-cycle clear.
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            restart_pending_q <= 1'b0;
        else if (ev_fail && restart_mode)
            restart_pending_q <= 1'b1;
        else if (ev_restart || ev_cancel)
            restart_pending_q <= 1'b0;
    end

    // Alarm is held until reset by software; a new alarm wins over the reset.
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            uv_alarm_q <= 1'b0;
        else if (ev_alarm)
            uv_alarm_q <= 1'b1;
        else if (alarm_reset)
            uv_alarm_q <= 1'b0;
    end

    // Frequency in use at the failure moment.
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            saved_freq_q <= FREQ_RST;
        else if (ev_fail)
            saved_freq_q <= output_freq;
    end

    // Target frequency for the frequency generator.
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            freq_cmd_q <= FREQ_RST;
        else if (ev_restart && cfg.power_loss_restart_mode == MODE_RESTART_SAVED)
            freq_cmd_q <= saved_freq_q;
        else if (ev_restart || ev_start)
            freq_cmd_q <= cfg.starting_frequency_setting;
    end

    // Output stage control and phase indicators follow the next state; restart_start_q follows the restart event.
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            output_enable_q <= 1'b0;
            decel_stop_q <= 1'b0;
            limit_active_q <= 1'b0;
            accel_back_q <= 1'b0;
            restart_start_q <= 1'b0;
        end
        else
        begin
            output_enable_q <= state_d inside {ST_RUN, ST_DECEL, ST_LIMIT, ST_ACCEL};
            decel_stop_q <= state_d == ST_DECEL;
            limit_active_q <= state_d == ST_LIMIT;
            accel_back_q <= state_d == ST_ACCEL;
            restart_start_q <= ev_restart;
        end
    end

    // Fall rate selection for the current limiter during restart.
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            fall_mode_q <= FALL_DECEL_TIME;
        else if (cfg.frequency_fall_rate == FALL_FOLLOW_DECEL)
            fall_mode_q <= FALL_DECEL_TIME;
        else if (cfg.frequency_fall_rate == FALL_PI_CODE)
            fall_mode_q <= FALL_FIXED_PI;
        else
            fall_mode_q <= FALL_SET_RATE;
    end

    trip_now_a: assert property (@(posedge sys_clk) disable iff (reset)
        state_q == ST_RUN && run_present && !coast_stop_command && mains.below_uv &&
        !mains.below_cont && cfg.power_loss_restart_mode == MODE_TRIP_NOW
        |=> uv_alarm_q && !output_enable_q)
        else $error("Immediate trip did not alarm and disable output.");

    recover_trip_a: assert property (@(posedge sys_clk) disable iff (reset)
        state_q == ST_RUN && run_present && !coast_stop_command && mains.below_uv &&
        cfg.power_loss_restart_mode == MODE_TRIP_RECOVER
        |=> !uv_alarm_q && !output_enable_q && state_q == ST_LOST)
        else $error("Trip after recovery alarmed or drove during the dip.");

    recover_alarm_a: assert property (@(posedge sys_clk) disable iff (reset)
        state_q == ST_LOST && !restart_pending_q && !mains.below_uv
        |=> uv_alarm_q && !output_enable_q)
        else $error("Trip after recovery did not alarm on power return.");

    decel_alarm_a: assert property (@(posedge sys_clk) disable iff (reset)
        state_q == ST_DECEL && decel_done |=> uv_alarm_q && !decel_stop_q)
        else $error("Decelerate to stop did not end in an alarm.");

    saved_freq_a: assert property (@(posedge sys_clk) disable iff (reset)
        $rose(restart_pending_q) |-> saved_freq_q == $past(output_freq) && !output_enable_q)
        else $error("Failure frequency not stored.");

    resume_freq_a: assert property (@(posedge sys_clk) disable iff (reset)
        restart_start_q && $past(cfg.power_loss_restart_mode) == MODE_RESTART_SAVED
        |-> freq_cmd_q == saved_freq_q && limit_active_q)
        else $error("Saved frequency restart used a wrong frequency.");

    start_freq_a: assert property (@(posedge sys_clk) disable iff (reset)
        restart_start_q && $past(cfg.power_loss_restart_mode) == MODE_RESTART_START
        |-> freq_cmd_q == $past(cfg.starting_frequency_setting))
        else $error("Starting frequency restart used a wrong frequency.");

    fail_running_a: assert property (@(posedge sys_clk) disable iff (reset)
        $rose(restart_pending_q) |-> $past(state_q) == ST_RUN)
        else $error("Failure recognised while not running.");

    delay_first_a: assert property (@(posedge sys_clk) disable iff (reset)
        restart_start_q |-> $past(dly_done) && !restart_pending_q)
        else $error("Restart began before the restart delay.");

    wait_cancel_a: assert property (@(posedge sys_clk) disable iff (reset)
        state_q == ST_WAIT_RUN && wait_done && !run_seen_q && !coast_stop_command &&
        !mains.below_uv |=> state_q == ST_STOP && !restart_pending_q)
        else $error("Missing run command did not cancel the restart.");

    coast_cancel_a: assert property (@(posedge sys_clk) disable iff (reset)
        state_q inside {ST_LOST, ST_CHARGE, ST_WAIT_RUN} && restart_pending_q &&
        coast_stop_command |=> !restart_pending_q && state_q == ST_STOP)
        else $error("Coast stop did not cancel the restart.");

    fixed_src_a: assert property (@(posedge sys_clk) disable iff (reset)
        state_q == ST_CHARGE && state_d == ST_WAIT_RUN && fixed_src |=> run_seen_q)
        else $error("Fixed direction source did not retain the run state.");

    limit_accel_a: assert property (@(posedge sys_clk) disable iff (reset)
        limit_active_q && speed_matched && !coast_stop_command |=> accel_back_q && output_enable_q)
        else $error("Speed match did not start acceleration back.");

endmodule

// File: test/plrs_stage_model.sv
// Model of the power stage and motor behind the sequencer.
// Assumes the sequencer's registered outputs on the same clock.
module plrs_stage_model
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic stage_on,
    input wire logic decel_req,
    input wire logic limit_req,
    input wire logic accel_req,
    input wire logic [15:0] freq_target,
    output logic decel_done,
    output logic speed_matched,
    output logic [15:0] output_freq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] phase_q;

    // Limiting and braking pull the frequency down; acceleration climbs back in steps.
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            phase_q <= 4'h0;
            output_freq <= 16'h0000;
        end
        // Limiting here stands for a stage whose instantaneous current limit is enabled.
        else if (limit_req || decel_req)
        begin
            phase_q <= phase_q + 4'h1;
            output_freq <= output_freq - 16'h0010;
        end
        else if (accel_req)
            output_freq <= output_freq + 16'h0010;
        else
        begin
            phase_q <= 4'h0;
            if (stage_on)
                output_freq <= freq_target;
        end
    end

    // Matching and the end of braking come late, so the sequencer must really wait.
    assign speed_matched = limit_req && (phase_q >= 4'h8);
    assign decel_done = decel_req && (phase_q >= 4'h5);
endmodule

// File: test/test_power_loss_restart_sequencer.sv
// Self-checking bench for the power loss restart sequencer.
// Assumes the package, the sequencer and the stage model are compiled first.
module test_power_loss_restart_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    import plrs_pkg::*;
    localparam logic [15:0] S1 = 16'h0100;
    localparam logic [15:0] S2 = 16'h0050;
    logic sys_clk;
    logic reset;
    plrs_cfg_type cfg;
    plrs_mains_type mains;
    logic keypad_run_command;
    logic forward_run_command;
    logic reverse_run_command;
    logic coast_stop_command;
    logic alarm_reset;
    logic decel_done;
    logic speed_matched;
    logic [15:0] output_freq;
    logic output_enable_q;
    logic uv_alarm_q;
    logic decel_stop_q;
    logic restart_pending_q;
    logic restart_start_q;
    logic limit_active_q;
    logic accel_back_q;
    plrs_fall_type fall_mode_q;
    logic [15:0] freq_cmd_q;
    logic [15:0] saved_freq_q;
    logic [16:0] rates [4] = '{17'h00000, 17'h00001, 17'h02710, FALL_PI_CODE};
    plrs_fall_type kinds [4] = '{FALL_DECEL_TIME, FALL_SET_RATE, FALL_SET_RATE, FALL_FIXED_PI};
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int fail_cyc = 0;
    int n;

    // A small tick divider keeps the two second window at 8000 cycles.
    plrs_sequencer #(.CYCLES_PER_MS(4)) i_plrs_sequencer
    (
        .sys_clk(sys_clk), .reset(reset), .cfg(cfg), .mains(mains),
        .keypad_run_command(keypad_run_command), .forward_run_command(forward_run_command),
        .reverse_run_command(reverse_run_command), .coast_stop_command(coast_stop_command),
        .alarm_reset(alarm_reset), .decel_done(decel_done), .speed_matched(speed_matched),
        .output_freq(output_freq), .output_enable_q(output_enable_q), .uv_alarm_q(uv_alarm_q),
        .decel_stop_q(decel_stop_q), .restart_pending_q(restart_pending_q),
        .restart_start_q(restart_start_q), .limit_active_q(limit_active_q),
        .accel_back_q(accel_back_q), .fall_mode_q(fall_mode_q), .freq_cmd_q(freq_cmd_q),
        .saved_freq_q(saved_freq_q)
    );

    plrs_stage_model i_plrs_stage_model
    (
        .sys_clk(sys_clk), .reset(reset), .stage_on(output_enable_q),
        .decel_req(decel_stop_q), .limit_req(limit_active_q), .accel_req(accel_back_q),
        .freq_target(freq_cmd_q), .decel_done(decel_done), .speed_matched(speed_matched),
        .output_freq(output_freq)
    );

    // Clock at 4 ns and a free cycle count for timing checks.
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) cyc <= cyc + 1;

    task automatic step(input int k);
        repeat (k) @(posedge sys_clk);
    endtask

    task automatic settle(input int k);
        step(k);
        #1;
    endtask

    task automatic check_bit(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic do_reset();
        reset <= 1'b1;
        {keypad_run_command, forward_run_command, reverse_run_command} <= 3'h0;
        coast_stop_command <= 1'b0;
        mains <= '{1'b0, 1'b0, 1'b1};
        cfg.starting_frequency_setting <= S1;
        step(2);
        reset <= 1'b0;
        step(1);
    endtask

    task automatic start_run(input logic [2:0] mode, input logic [1:0] src, input logic [2:0] run);
        cfg.power_loss_restart_mode <= mode;
        cfg.run_command_source <= src;
        {keypad_run_command, forward_run_command, reverse_run_command} <= run;
        settle(4);
        check_bit("start enable", 1'b1, output_enable_q);
        step(1);
    endtask

    // The dip also drops charge, as a real link would.
    task automatic fail_power();
        mains.below_uv <= 1'b1;
        mains.charge_done <= 1'b0;
        fail_cyc = cyc;
        settle(3);
    endtask

    task automatic restore();
        step(1);
        mains.below_uv <= 1'b0;
        step(2);
        mains.charge_done <= 1'b1;
    endtask

    task automatic wait_restart();
        n = 0;
        do
        begin
            settle(1);
            n++;
        end
        while (restart_start_q !== 1'b1 && n < 9000);
    endtask

    task automatic complete_run();
        $display("counts: %0d compared, %0d failed", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // The delay of 10 ms stands in for a residual-voltage decay time.
    initial
    begin
        reset = 1'b1;
        cfg = '{MODE_RESTART_SAVED, SRC_KEYPAD_TERM, FALL_FOLLOW_DECEL, S1, 16'h000A};
        mains = '{1'b0, 1'b0, 1'b1};
        {keypad_run_command, forward_run_command, reverse_run_command} = 3'h0;
        coast_stop_command = 1'b0;
        alarm_reset = 1'b0;
        step(20);
        reset <= 1'b0;
        step(1);
        fail_power();
        check_bit("idle pending", 1'b0, restart_pending_q);
        check_bit("idle alarm", 1'b0, uv_alarm_q);
        restore();
        $display("test idle dip done");
        start_run(MODE_TRIP_NOW, SRC_KEYPAD_TERM, 3'h4);
        fail_power();
        check_bit("trip alarm", 1'b1, uv_alarm_q);
        check_bit("trip enable", 1'b0, output_enable_q);
        step(1);
        alarm_reset <= 1'b1;
        step(1);
        alarm_reset <= 1'b0;
        settle(2);
        check_bit("alarm reset", 1'b0, uv_alarm_q);
        $display("test trip now done");
        do_reset();
        start_run(MODE_TRIP_RECOVER, SRC_KEYPAD_TERM, 3'h4);
        fail_power();
        check_bit("dip enable", 1'b0, output_enable_q);
        check_bit("dip alarm", 1'b0, uv_alarm_q);
        restore();
        settle(1);
        check_bit("return alarm", 1'b1, uv_alarm_q);
        check_bit("return enable", 1'b0, output_enable_q);
        $display("test trip recover done");
        do_reset();
        start_run(MODE_DECEL_TRIP, SRC_KEYPAD_TERM, 3'h4);
        mains.below_cont <= 1'b1;
        settle(3);
        check_bit("decel active", 1'b1, decel_stop_q);
        check_bit("decel alarm", 1'b0, uv_alarm_q);
        settle(10);
        check_bit("decel end alarm", 1'b1, uv_alarm_q);
        check_bit("decel end enable", 1'b0, output_enable_q);
        $display("test decel trip done");
        do_reset();
        start_run(MODE_RESTART_SAVED, SRC_KEYPAD_TERM, 3'h4);
        fail_power();
        check_bit("coast enable", 1'b0, output_enable_q);
        check_bit("pending", 1'b1, restart_pending_q);
        check_word("saved freq", S1, saved_freq_q);
        step(1);
        cfg.starting_frequency_setting <= S2;
        restore();
        wait_restart();
        check_bit("delay elapsed", 1'b1, (cyc - fail_cyc) >= 42);
        check_word("resume freq", S1, freq_cmd_q);
        check_bit("limit", 1'b1, limit_active_q);
        check_bit("pending clear", 1'b0, restart_pending_q);
        n = 0;
        while (accel_back_q !== 1'b1 && n < 50)
        begin
            settle(1);
            n++;
        end
        check_bit("accel", 1'b1, accel_back_q);
        check_bit("lowered", 1'b1, output_freq < S1);
        settle(30);
        check_bit("back run", 1'b0, accel_back_q);
        check_word("back freq", S1, output_freq);
        $display("test saved restart done");
        for (int src = 2; src < 4; src++)
        begin
            do_reset();
            start_run(MODE_RESTART_START, 2'(src), (src == 2) ? 3'h2 : 3'h1);
            fail_power();
            step(1);
            {keypad_run_command, forward_run_command, reverse_run_command} <= 3'h0;
            cfg.starting_frequency_setting <= S2;
            restore();
            wait_restart();
            check_bit("held run restart", 1'b1, restart_start_q);
            check_bit("prompt restart", 1'b1, (cyc - fail_cyc) <= 60);
            check_word("start freq", S2, freq_cmd_q);
        end
        $display("test fixed source done");
        do_reset();
        start_run(MODE_RESTART_START, SRC_KEYPAD_TERM, 3'h4);
        fail_power();
        step(1);
        keypad_run_command <= 1'b0;
        cfg.starting_frequency_setting <= S2;
        restore();
        wait_restart();
        check_bit("no restart", 1'b0, restart_start_q);
        check_bit("window cancel", 1'b0, restart_pending_q);
        step(1);
        keypad_run_command <= 1'b1;
        settle(4);
        check_word("fresh start", S2, freq_cmd_q);
        $display("test window expiry done");
        do_reset();
        start_run(MODE_RESTART_SAVED, SRC_KEYPAD_TERM, 3'h4);
        fail_power();
        step(1);
        coast_stop_command <= 1'b1;
        settle(3);
        check_bit("coast cancel", 1'b0, restart_pending_q);
        step(1);
        coast_stop_command <= 1'b0;
        cfg.starting_frequency_setting <= S2;
        restore();
        settle(4);
        check_word("normal start", S2, freq_cmd_q);
        check_bit("normal enable", 1'b1, output_enable_q);
        $display("test coast cancel done");
        for (int i = 0; i < 4; i++)
        begin
            step(1);
            cfg.frequency_fall_rate <= rates[i];
            settle(3);
            check_word("fall mode", 16'(kinds[i]), 16'(fall_mode_q));
        end
        $display("test fall rate done");
        complete_run();
    end

    // The tests need about 9400 cycles; four times that means a hang.
    initial
    begin
        repeat (40000) @(posedge sys_clk);
        fail_count++;
        complete_run();
    end
endmodule
